/* File: logic/loader_pkg.sv */
// Shared constants and carrier types for the configuration loader.
// Assumes one 125 MHz clock domain and a byte-read memory master beside it.
package loader_pkg;

  // ****************************************
  // Memory layout
  // ****************************************
  localparam int          MEM_AW        = 11;    // Slot start reach: 3 high bits + 8 low
  localparam int          BASE_LEN      = 3;     // Base header bytes 0..2
  localparam int          HDR_LEN_BIG   = 3;     // Header bytes when memory > 256 bytes
  localparam int          HDR_LEN_SMALL = 2;     // Header bytes otherwise
  localparam int          HDR_BASE      = 3;     // First header location
  localparam logic [7:0]  BUS_ADDR_LOW  = 8'h30; // Lowest bus write address
  localparam int          CRC_EN_BIT    = 7;     // Byte 0 flag positions
  localparam int          MAP_BIT       = 6;
  localparam int          BIG_BIT       = 5;
  localparam int          SHARED_BIT    = 4;
  localparam int          BURST_POS     = 2;     // Base byte holding burst limit
  localparam logic [7:0]  CRC_POLY      = 8'h07; // CRC-8 polynomial
  localparam logic [7:0]  CRC_INIT      = 8'h00; // CRC-8 start value
  localparam int          BOOT_WAIT     = 3;     // Cycles for strap synchroniser to fill

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0]  REG_CTRL   = 8'h00;   // W: bit0 restart
  localparam logic [7:0]  REG_STATUS = 8'h04;   // R: sticky events
  localparam logic [7:0]  REG_CLEAR  = 8'h08;   // W: clear events
  localparam logic [7:0]  REG_ENABLE = 8'h0C;   // RW: event enables
  localparam logic [7:0]  REG_FLAGS  = 8'h10;   // R: decoded byte 0, burst limit
  localparam logic [7:0]  REG_SLOT   = 8'h14;   // R: slot start address
  localparam logic [7:0]  REG_CRC    = 8'h18;   // R: stored and computed CRC
  localparam logic [7:0]  REG_STATE  = 8'h1C;   // R: state, bus address index
  localparam int          EV_DONE    = 0;       // Event bit positions
  localparam int          EV_FAIL    = 1;
  localparam int          EV_NOMAP   = 2;
  localparam int          EV_W       = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    S_BOOT, S_BASE, S_HDR, S_SLOT, S_CHECK, S_DONE
  } state_e;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } reg_req_s;

  // Byte read request towards the memory master
  typedef struct packed {
    logic              req;   // One-cycle pulse
    logic              seq;   // Continue current burst at next address
    logic [MEM_AW-1:0] addr;
  } mem_req_s;

  // Byte answer from the memory master
  typedef struct packed {
    logic       ack;
    logic [7:0] data;
  } mem_rsp_s;

  // Staged slot byte towards the configuration registers
  typedef struct packed {
    logic              valid;
    logic [MEM_AW-1:0] idx;
    logic [7:0]        data;
  } cfg_byte_s;

endpackage

/* File: logic/eeprom_map_header_loader.sv */
// Power-up loader: reads base header, own address-map header and data slot.
// Assumes a memory master on the same clock that answers each byte request.
// Notes on behaviour
// RULE_01: header is 3 bytes if big, else 2
// RULE_02: read exactly that header at fixed location
// RULE_03: CRC covers every fetched byte but itself
// RULE_04: low byte, then high bits 2:0 if big
// RULE_05: slot start is high shifted eight plus low
// RULE_06: byte 0 bits: CRC, maps, big memory
// RULE_07: device count and byte 1 are ignored
// RULE_08: byte 2 caps bytes per burst
// RULE_09: CRC mismatch discards fetched data
// RULE_10: CRC disabled means data always applied
// RULE_11: address 0x30 reads 0x003, 0x32 reads 0x006
// RULE_12: without shared flag, read every channel separately
// RULE_13: header location is 3 plus index times length
// RULE_14: byte 0 bit 4 is shared channel flag
// RULE_15: on discard keep defaults, flag failure
// RULE_16: random read then sequential ascending reads
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module eeprom_map_header_loader
  import loader_pkg::*;
#(
  parameter int CHAN_BYTES   = 74,  // Register bytes per channel image
  parameter int CHANNELS     = 4,   // Channels per device
  parameter int SHARED_BYTES = 2    // Shared register bytes per slot
) (
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      rst,
  // Strapped bus write address
  input  wire logic [7:0] bus_addr,
  // Register port
  input  wire reg_req_s  reg_req,
  output logic [31:0]    reg_rdata,
  // Memory master
  output mem_req_s       mem_req,
  input  wire mem_rsp_s  mem_rsp,
  // Configuration stream
  output cfg_byte_s      cfg_out,
  output logic           cfg_commit,
  output logic           cfg_discard,
  // Interrupt
  output logic           irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    state_e            st;
    logic [7:0]        sync1;      // Strap synchroniser
    logic [7:0]        sync2;
    logic [7:0]        sync3;
    logic [3:0]        bus_idx;    // bus_address_index
    logic [MEM_AW-1:0] addr;       // Next byte to fetch
    logic [MEM_AW-1:0] cnt;        // Bytes left in phase
    logic              waiting;    // Request out, answer pending
    logic              cont;       // A burst is open
    logic [7:0]        burst_cnt;  // Bytes in current burst
    logic [7:0]        burst_lim;
    logic              crc_en;
    logic              map_on;
    logic              big;
    logic              shared_channel_flag;
    logic [7:0]        crc_calc;
    logic [7:0]        crc_stored;
    logic [7:0]        slot_start_low;
    logic [2:0]        slot_start_high;
    mem_req_s          mreq;
    cfg_byte_s         cfg;
    logic              commit;
    logic              discard;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   enable;
    logic              irq;
    logic [31:0]       rdata;
  } st_s;

  st_s q;   // Registered state
  st_s d;   // Next state

  // ****************************************
  // Helpers
  // ****************************************
  // CRC-8 over one byte, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Header length from size flag
  function automatic logic [MEM_AW-1:0] hdr_len(input logic big);
    return big ? MEM_AW'(HDR_LEN_BIG) : MEM_AW'(HDR_LEN_SMALL);
  endfunction

  // Slot length: one shared image or one per channel
  function automatic logic [MEM_AW-1:0] slot_len(input logic shared);
    return shared ? MEM_AW'(CHAN_BYTES + SHARED_BYTES)
                  : MEM_AW'(CHAN_BYTES * CHANNELS + SHARED_BYTES);
  endfunction

  logic [7:0]        lim_eff;    // Burst cap in force
  logic [MEM_AW-1:0] pos;        // Byte position in current phase
  logic [EV_W-1:0]   ev_set;     // Events raised this cycle
  logic              got;        // Answer taken this cycle

  // Base header goes in one burst; the cap is known only after it
  assign lim_eff = (q.st == S_BASE) ? 8'(BASE_LEN)
                 : ((q.burst_lim == 8'h00) ? 8'h01 : q.burst_lim);
  assign got = q.waiting && mem_rsp.ack;
  assign pos = ((q.st == S_BASE) ? MEM_AW'(BASE_LEN)
             : (q.st == S_HDR) ? hdr_len(q.big) : slot_len(q.shared_channel_flag)) - q.cnt;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    ev_set = '0;
    d.sync1 = bus_addr;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.mreq.req = 1'b0;
    d.cfg.valid = 1'b0;
    d.commit = 1'b0;
    d.discard = 1'b0;

    // Issue one byte request when idle inside a fetch phase
    if ((q.st == S_BASE || q.st == S_HDR || q.st == S_SLOT) && !q.waiting) begin
      d.mreq.req = 1'b1;
      d.mreq.addr = q.addr;
      // RULE_16 random then sequential
      // RULE_08 cap burst length
      d.mreq.seq = q.cont && (q.burst_cnt < lim_eff);
      if (!d.mreq.seq) begin
        d.burst_cnt = 8'h00;
      end
      d.waiting = 1'b1;
    end

    // Common bookkeeping for an answered byte
    if (got) begin
      d.waiting = 1'b0;
      d.burst_cnt = d.burst_cnt + 8'h01;
      d.addr = q.addr + MEM_AW'(1);
      d.cnt = q.cnt - MEM_AW'(1);
      d.cont = 1'b1;
    end

    unique case (q.st)
      // Wait for the strap to settle, then latch the index
      S_BOOT: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - MEM_AW'(1);
        end else if (q.sync2 == q.sync3) begin
          // RULE_13 index from write address
          d.bus_idx = 4'((q.sync3 - BUS_ADDR_LOW) >> 1);
          d.st = S_BASE;
          d.addr = '0;
          d.cnt = MEM_AW'(BASE_LEN);
          d.cont = 1'b0;
          d.crc_calc = CRC_INIT;
        end
      end
      // Base header bytes 0..2
      S_BASE: begin
        if (got) begin
          // RULE_03 fold fetched byte
          d.crc_calc = crc8(q.crc_calc, mem_rsp.data);
          if (pos == '0) begin
            // RULE_06 decode byte 0
            d.crc_en = mem_rsp.data[CRC_EN_BIT];
            d.map_on = mem_rsp.data[MAP_BIT];
            d.big = mem_rsp.data[BIG_BIT];
            // RULE_14 shared channel flag
            d.shared_channel_flag = mem_rsp.data[SHARED_BIT];
          end else if (pos == MEM_AW'(BURST_POS)) begin
            // RULE_08 latch burst limit
            d.burst_lim = mem_rsp.data;
          end
          // RULE_07 count bits and byte 1 unused
          if (q.cnt == MEM_AW'(1)) begin
            if (!q.map_on) begin
              // Slot placement without maps is not handled here
              d.st = S_DONE;
              d.discard = 1'b1;
              ev_set[EV_NOMAP] = 1'b1;
            end else begin
              d.st = S_HDR;
              // RULE_16 fresh random read
              d.cont = 1'b0;
              // RULE_11 fixed location per address
              // RULE_13 three plus index times length
              d.addr = MEM_AW'(HDR_BASE) + MEM_AW'(q.bus_idx) * hdr_len(q.big);
              // RULE_01 header length by size
              // RULE_02 consume exactly that many
              d.cnt = hdr_len(q.big);
            end
          end
        end
      end
      // Own address-map header
      S_HDR: begin
        if (got) begin
          if (pos == '0) begin
            // RULE_03 stored CRC not folded
            d.crc_stored = mem_rsp.data;
          end else begin
            d.crc_calc = crc8(q.crc_calc, mem_rsp.data);
            // RULE_04 low byte then high bits
            if (pos == MEM_AW'(1)) begin
              d.slot_start_low = mem_rsp.data;
              d.slot_start_high = 3'h0;
            end else begin
              d.slot_start_high = mem_rsp.data[2:0];
            end
          end
          if (q.cnt == MEM_AW'(1)) begin
            d.st = S_SLOT;
            // RULE_16 fresh random read
            d.cont = 1'b0;
            // RULE_05 high shifted eight plus low
            d.addr = (MEM_AW'(d.slot_start_high) << 8) + MEM_AW'(d.slot_start_low);
            // RULE_12 per-channel images unless shared
            d.cnt = slot_len(q.shared_channel_flag);
          end
        end
      end
      // Slot bytes are staged out, applied only on commit
      S_SLOT: begin
        if (got) begin
          d.crc_calc = crc8(q.crc_calc, mem_rsp.data);
          d.cfg.valid = 1'b1;
          d.cfg.idx = pos;
          d.cfg.data = mem_rsp.data;
          if (q.cnt == MEM_AW'(1)) begin
            d.st = S_CHECK;
          end
        end
      end
      // Compare and decide
      S_CHECK: begin
        d.st = S_DONE;
        if (q.crc_en && (q.crc_calc != q.crc_stored)) begin
          // RULE_09 mismatch discards
          // RULE_15 defaults kept, failure flagged
          d.discard = 1'b1;
          ev_set[EV_FAIL] = 1'b1;
        end else begin
          // RULE_10 CRC ignored when disabled
          d.commit = 1'b1;
          ev_set[EV_DONE] = 1'b1;
        end
      end
      // Rest until software asks for another load
      S_DONE: begin
        if (reg_req.we && reg_req.addr == REG_CTRL && reg_req.wdata[0]) begin
          d.st = S_BOOT;
          d.cnt = MEM_AW'(BOOT_WAIT);
        end
      end
    endcase

    // Register writes
    if (reg_req.we && reg_req.addr == REG_ENABLE) begin
      d.enable = reg_req.wdata[EV_W-1:0];
    end
    // Set wins over a clear in the same cycle
    if (reg_req.we && reg_req.addr == REG_CLEAR) begin
      d.status = q.status & ~reg_req.wdata[EV_W-1:0];
    end
    d.status = d.status | ev_set;
    d.irq = |(d.status & d.enable);

    // Read data stands the cycle after the strobe only
    d.rdata = 32'h0;
    if (reg_req.re) begin
      unique case (reg_req.addr)
        REG_STATUS: d.rdata = 32'(q.status);
        REG_ENABLE: d.rdata = 32'(q.enable);
        REG_FLAGS:  d.rdata = {16'h0, q.burst_lim, 4'h0, q.crc_en, q.map_on,
                               q.big, q.shared_channel_flag};
        REG_SLOT:   d.rdata = 32'({q.slot_start_high, q.slot_start_low});
        REG_CRC:    d.rdata = {16'h0, q.crc_stored, q.crc_calc};
        REG_STATE:  d.rdata = {24'h0, q.bus_idx, 1'b0, q.st};
        default:    d.rdata = 32'h0;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= S_BOOT;
      q.cnt <= MEM_AW'(BOOT_WAIT);
      q.crc_calc <= CRC_INIT;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = q.rdata;
  assign mem_req = q.mreq;
  assign cfg_out = q.cfg;
  assign cfg_commit = q.commit;
  assign cfg_discard = q.discard;
  assign irq = q.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  hdr_length_a: assert property ($changed(q.st) && q.st == S_HDR |-> // RULE_01
    q.cnt == (q.big ? MEM_AW'(3) : MEM_AW'(2))) else $error("header length wrong");
  hdr_place_a: assert property ($changed(q.st) && q.st == S_HDR |-> // RULE_13
    q.addr == MEM_AW'(3) + MEM_AW'(q.bus_idx) * hdr_len(q.big)) else $error("header place");
  crc_skip_a: assert property (q.st == S_HDR && got && pos == '0 |=> // RULE_03
    $stable(q.crc_calc)) else $error("stored CRC folded in");
  slot_start_a: assert property ($changed(q.st) && q.st == S_SLOT |-> // RULE_05
    q.addr == {q.slot_start_high, q.slot_start_low}) else $error("slot start wrong");
  slot_size_a: assert property ($changed(q.st) && q.st == S_SLOT |-> // RULE_12
    q.cnt == slot_len(q.shared_channel_flag)) else $error("slot length wrong");
  burst_cap_a: assert property (q.mreq.req && q.mreq.seq |-> // RULE_08
    q.burst_cnt < $past(lim_eff) && q.burst_cnt != 8'h00) else $error("burst too long");
  flag_decode_a: assert property (q.st == S_BASE && got && pos == '0 |=> // RULE_06
    q.crc_en == $past(mem_rsp.data[7]) && q.big == $past(mem_rsp.data[5]))
    else $error("flags decoded wrong");
  crc_drop_a: assert property (q.st == S_CHECK && q.crc_en && q.crc_calc != q.crc_stored // RULE_09
    |=> q.discard && !q.commit ##1 q.status[EV_FAIL]) else $error("bad CRC not dropped");
  crc_off_a: assert property (q.st == S_CHECK && !q.crc_en |=> q.commit) // RULE_10
    else $error("disabled CRC blocked load");

  load_ok_c: cover property (q.commit);
  load_bad_c: cover property (q.discard && q.status[EV_FAIL]);
  no_map_c: cover property (q.status[EV_NOMAP]);
  split_burst_c: cover property (q.st == S_SLOT && q.mreq.req && !q.mreq.seq);

endmodule

`default_nettype wire

/* File: tb/eeprom_model.sv */
// Behavioural serial configuration memory that answers the loader's byte reads.
// Assumes the loader's one-clock request/ack link; contents are loaded by the bench.
`timescale 1ns/1ps
`default_nettype none

module eeprom_model
  import loader_pkg::*;
(
  // Clock and reset
  input  wire logic     clock,
  input  wire logic     rst,
  // Byte link
  input  wire mem_req_s mem_req,
  output var  mem_rsp_s mem_rsp,
  // Observation for the bench
  output var  int       bad_count,
  output var  int       ack_count,
  output var  int       hdr_at
);
  logic [7:0]        mem [0:2047];  // Contents, written by the bench
  logic [MEM_AW-1:0] last_q;        // Address of latest request
  logic [MEM_AW-1:0] start_q;       // First address of the open burst
  int                burst_q;       // Bytes in the open burst
  int                starts_q;      // Random-address reads seen
  int                wait_q;        // Cycles left before answering
  logic              pend_q;        // Request outstanding
  int                lim;           // Burst cap, zero read as one

  assign lim = (mem[2] == 8'h00) ? 1 : int'(mem[2]);

  // One request at a time; delay varies 0..2 extra cycles so slow answers occur
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q    <= 1'b0;
      mem_rsp   <= '0;
      bad_count <= 0;
      ack_count <= 0;
      starts_q  <= 0;
      hdr_at    <= -1;
    end else begin
      // Released data line toggles so a stale byte is never mistaken for an answer
      mem_rsp.ack  <= 1'b0;
      mem_rsp.data <= ~mem_rsp.data;
      if (mem_req.req) begin
        if (pend_q || (mem_req.seq && mem_req.addr != last_q + 1'b1))
          bad_count <= bad_count + 1;
        if (mem_req.seq && start_q != '0 && burst_q >= lim)
          bad_count <= bad_count + 1;
        burst_q  <= mem_req.seq ? burst_q + 1 : 1;
        start_q  <= mem_req.seq ? start_q : mem_req.addr;
        starts_q <= starts_q + (mem_req.seq ? 0 : 1);
        if (!mem_req.seq && starts_q == 1)
          hdr_at <= int'(mem_req.addr);
        last_q <= mem_req.addr;
        pend_q <= 1'b1;
        wait_q <= ack_count % 3;
      end else if (pend_q) begin
        if (wait_q == 0) begin
          mem_rsp   <= '{1'b1, mem[last_q]};
          pend_q    <= 1'b0;
          ack_count <= ack_count + 1;
        end else begin
          wait_q <= wait_q - 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/eeprom_map_header_loader_test.sv */
// Bench: builds memory images, boots the loader and checks outcome and registers.
// Assumes the loader and memory model share one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module eeprom_map_header_loader_test
  import loader_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic        clock;            // 8 ns period
  logic        rst;              // Async, active high
  logic [7:0]  bus_addr;         // Strapped address
  reg_req_s    reg_req;          // Register request
  logic [31:0] reg_rdata;        // Register answer
  mem_req_s    mem_req;          // Byte request
  mem_rsp_s    mem_rsp;          // Byte answer
  cfg_byte_s   cfg_out;          // Slot byte stream
  logic        cfg_commit;       // Apply pulse
  logic        cfg_discard;      // Drop pulse
  logic        irq;              // Level interrupt
  int          bad_count;        // Link faults seen by the model
  int          ack_count;        // Bytes fetched
  int          hdr_at;           // Header start address
  int          miscompares;      // Mismatch count
  int          samples_checked;  // Comparison count
  int          cfg_n;            // Slot bytes streamed
  int          slot_exp;         // Expected slot start
  int          got;              // Load outcome

  // ****************************************
  // Design and memory
  // ****************************************
  eeprom_map_header_loader dut_u (
    .clock(clock), .rst(rst), .bus_addr(bus_addr), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rsp(mem_rsp), .cfg_out(cfg_out),
    .cfg_commit(cfg_commit), .cfg_discard(cfg_discard), .irq(irq));

  eeprom_model mem_u (
    .clock(clock), .rst(rst), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .bad_count(bad_count), .ack_count(ack_count), .hdr_at(hdr_at));

  // Free-running clock
  always #4 clock = ~clock;

  // Slot stream must follow the decoded start address in order
  always @(posedge clock) begin
    if (cfg_out.valid === 1'b1) begin
      `CHK("cfg_idx", MEM_AW'(cfg_n), cfg_out.idx)
      `CHK("cfg_data", mem_u.mem[slot_exp + cfg_n], cfg_out.data)
      cfg_n++;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    reg_req <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clock);
    reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    reg_req <= '0;
    @(negedge clock);
    `CHK(nm, e, reg_rdata)
  endtask

  // Bounded wait: 1 commit, 2 discard, 3 both
  task automatic wait_end(output int r);
    r = 0;
    for (int i = 0; i < 4000 && r == 0; i++) begin
      @(posedge clock);
      r = (cfg_commit === 1'b1 ? 1 : 0) + (cfg_discard === 1'b1 ? 2 : 0);
    end
    if (r == 0) begin
      miscompares++;
      $display("mismatch load_end expected done seen timeout");
      tally_and_finish();
    end
  endtask

  // CRC-8, polynomial 0x07, zero start, MSB first
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int k = 0; k < 8; k++) r = r[7] ? (r << 1) ^ 8'h07 : r << 1;
    return r;
  endfunction

  // Build an image, boot the loader, then check fetch, outcome and registers
  task automatic run(input logic [7:0] b0, input logic [7:0] ba, input logic [7:0] lim,
                     input int slot, input bit bad);
    int         len, idx, hloc, slen, exp_out;
    logic [7:0] c;
    len      = b0[5] ? 3 : 2;
    idx      = (ba - 8'h30) >> 1;
    hloc     = 3 + idx * len;
    slen     = b0[4] ? 76 : 298;
    slot_exp = b0[5] ? slot : (slot & 8'hFF);
    for (int i = 0; i < 2048; i++) mem_u.mem[i] = 8'(i * 13 + 5) ^ 8'(i >> 8);
    mem_u.mem[0]        = b0;
    mem_u.mem[1]        = 8'hA5;
    mem_u.mem[2]        = lim;
    mem_u.mem[hloc + 1] = slot[7:0];
    mem_u.mem[hloc + 2] = {5'h15, slot[10:8]};
    c = 8'h00;
    for (int i = 0; i < 3; i++) c = crc_step(c, mem_u.mem[i]);
    for (int i = 1; i < len; i++) c = crc_step(c, mem_u.mem[hloc + i]);
    for (int i = 0; i < slen; i++) c = crc_step(c, mem_u.mem[slot_exp + i]);
    mem_u.mem[hloc] = bad ? c ^ 8'h5A : c;
    exp_out = (!b0[6] || (b0[7] && bad)) ? 2 : 1;
    // Drive strap and reset just after a rising edge
    @(posedge clock);
    bus_addr <= ba;
    rst      <= 1'b1;
    cfg_n = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    wait_end(got);
    `CHK("outcome", exp_out, got)
    `CHK("fetched", b0[6] ? 3 + len + slen : 3, ack_count)
    `CHK("link_bad", 0, bad_count)
    rd(REG_FLAGS, {16'h0, lim, 4'h0, b0[7:4]}, "flags");
    rd(REG_STATUS, b0[6] ? exp_out : 4, "status");
    rd(REG_STATE, {24'h0, 4'(idx), 4'h5}, "state");
    if (b0[6]) begin
      `CHK("hdr_loc", hloc, hdr_at)
      `CHK("slot_bytes", slen, cfg_n)
      rd(REG_SLOT, 32'(slot_exp), "slot");
      rd(REG_CRC, {16'h0, mem_u.mem[hloc], c}, "crc");
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clock           = 1'b0;
    rst             = 1'b1;
    bus_addr        = 8'h30;
    reg_req         = '0;
    miscompares     = 0;
    samples_checked = 0;
    cfg_n           = 0;
    slot_exp        = 0;
    run(8'hF5, 8'h32, 8'h10, 'h15D, 1'b0);
    // Interrupt raised, masked, re-enabled and cleared
    wr(REG_ENABLE, 32'h1);
    repeat (2) @(negedge clock);
    `CHK("irq_on", 1'b1, irq)
    wr(REG_ENABLE, 32'h0);
    repeat (2) @(negedge clock);
    `CHK("irq_masked", 1'b0, irq)
    wr(REG_ENABLE, 32'h7);
    rd(REG_ENABLE, 32'h7, "enable");
    wr(REG_CLEAR, 32'h1);
    repeat (2) @(negedge clock);
    `CHK("irq_cleared", 1'b0, irq)
    rd(REG_STATUS, 32'h0, "cleared");
    rd(8'h24, 32'h0, "unmapped");
    run(8'hF0, 8'h32, 8'h10, 'h15D, 1'b1);
    run(8'h70, 8'h30, 8'h10, 'h033, 1'b1);
    run(8'hD0, 8'h34, 8'h00, 'h540, 1'b0);
    run(8'hE0, 8'h4E, 8'h10, 'h287, 1'b0);
    run(8'h90, 8'h3A, 8'h10, 'h100, 1'b0);
    // Restart from rest: base header fetched again, still no maps
    wr(REG_CTRL, 32'h1);
    wait_end(got);
    `CHK("restart", 2, got)
    `CHK("refetched", 6, ack_count)
    tally_and_finish();
  end
endmodule
`default_nettype wire
